// *** verilog/scr_top.sv ***
// Purpose: AXI4-Lite register front end of the system controller: interrupt
//          enables, sticky flags, loop and brown-out synchronisation.
// Assumes: One 10 MHz clock, synchronous active-high reset, inputs synchronous.
// Notes:   Sync delays model the slow domains by a cycle counter.
//
// Functional notes
// - Registers accept 8-, 16- and 32-bit atomic accesses.
// - Each byte lane of a register is written independently via wstrb.
// - Synchronised registers finish a sync step before a read completes; a brown-out write waits only for a running sync, then starts one.
// - Write-protect input blocks every write to protected registers.
// - Writing zero to an enable-clear bit leaves that enable unchanged.
// - Writing one to an enable-clear bit clears that enable.
// - Interrupt requested while any enabled flag is set; disabled sources are silent.
// - Brown-out sync-ready enable sits at bit 11.
// - Brown-out control write clears sync-ready, sync completion sets it again.
// - Loop reads without prior read request start sync and stall the bus.
`timescale 1ns/1ns
`default_nettype none
`include "scr_regs.svh"

module scr_top #(
    parameter int SYNC_CYCLES = `SCR_SYNC_CYCLES
) (
    // Clock and reset.
    input  wire logic                 sys_clk_in,
    input  wire logic                 sys_rst_in,
    // AXI4-Lite slave.
    input  wire scr_pkg::scr_wr_req_t wr_req_in,
    output var  scr_pkg::scr_wr_rsp_t wr_rsp_out,
    input  wire scr_pkg::scr_rd_req_t rd_req_in,
    output var  scr_pkg::scr_rd_rsp_t rd_rsp_out,
    // Controller events and levels.
    input  wire logic [10:0]          src_event_in,
    input  wire logic [10:0]          src_status_in,
    input  wire logic                 write_protect_in,
    // Control values and interrupt.
    output var  scr_pkg::scr_ctrl_t   ctrl_out,
    output var  logic                 irq_out
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    if (SYNC_CYCLES < 1 || SYNC_CYCLES > 255) begin : g_bad_sync
        $error("SYNC_CYCLES must lie between 1 and 255");
    end

    localparam logic [7:0] SYNC_LOAD = 8'(SYNC_CYCLES - 1);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic scr_pkg::scr_reg_t scr_decode(input logic [7:0] addr);
        logic [7:0] a;
        a = {addr[7:2], 2'b00};
        if (a == `SCR_OFF_IEN_CLR) begin
            return scr_pkg::SCR_REG_IEN_CLR;
        end else if (a == `SCR_OFF_IEN_SET) begin
            return scr_pkg::SCR_REG_IEN_SET;
        end else if (a == `SCR_OFF_FLAGS) begin
            return scr_pkg::SCR_REG_FLAGS;
        end else if (a == `SCR_OFF_STATUS) begin
            return scr_pkg::SCR_REG_STATUS;
        end else if (a == `SCR_OFF_FLAG_CLR) begin
            return scr_pkg::SCR_REG_FLAG_CLR;
        end else if (a == `SCR_OFF_LOOP_VAL) begin
            return scr_pkg::SCR_REG_LOOP_VAL;
        end else if (a == `SCR_OFF_LOOP_MUL) begin
            return scr_pkg::SCR_REG_LOOP_MUL;
        end else if (a == `SCR_OFF_LOOP_SYNC) begin
            return scr_pkg::SCR_REG_LOOP_SYNC;
        end else if (a == `SCR_OFF_BOD) begin
            return scr_pkg::SCR_REG_BOD;
        end else if (a == `SCR_OFF_REGULATOR) begin
            return scr_pkg::SCR_REG_REGULATOR;
        end else if (a == `SCR_OFF_VREF) begin
            return scr_pkg::SCR_REG_VREF;
        end else begin
            return scr_pkg::SCR_REG_NONE;
        end
    endfunction : scr_decode

    // Byte lanes turn 8-, 16- and 32-bit accesses into one masked update.
    function automatic logic [31:0] scr_lanes(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : scr_lanes

    function automatic logic [31:0] scr_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [31:0] m);
        return (old & ~m) | (wd & m);
    endfunction : scr_merge

    // ****************************************************************
    // State
    // ****************************************************************
    logic [11:0]         ien;
    logic [11:0]         flags;
    scr_pkg::scr_sync_t  bod_st;
    scr_pkg::scr_sync_t  loop_st;
    logic [7:0]          bod_cnt;
    logic [7:0]          loop_cnt;
    logic [7:0]          aw_addr;
    logic [7:0]          ar_addr;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;

    logic [11:0]         next_ien;
    logic [11:0]         next_flags;
    scr_pkg::scr_sync_t  next_bod_st;
    scr_pkg::scr_sync_t  next_loop_st;
    logic [7:0]          next_bod_cnt;
    logic [7:0]          next_loop_cnt;
    logic [7:0]          next_aw_addr;
    logic [7:0]          next_ar_addr;
    logic [31:0]         next_w_data;
    logic [3:0]          next_w_strb;
    scr_pkg::scr_wr_rsp_t next_wr_rsp;
    scr_pkg::scr_rd_rsp_t next_rd_rsp;
    scr_pkg::scr_ctrl_t  next_ctrl;
    logic                next_irq;

    // ****************************************************************
    // Decode and handshake terms
    // ****************************************************************
    scr_pkg::scr_reg_t   wr_sel;
    scr_pkg::scr_reg_t   rd_sel;
    logic [31:0]         bmask;
    logic                bod_run;
    logic                wr_go;
    logic                wr_prot;
    logic                rd_loop;
    logic                rd_wait;
    logic                rd_go;
    logic                bod_done;
    logic [11:0]         flag_clr;
    logic [31:0]         rd_value;

    always_comb begin
        wr_sel  = scr_decode(aw_addr);
        rd_sel  = scr_decode(ar_addr);
        bmask   = w_data & scr_lanes(w_strb);
        bod_run = (bod_st == scr_pkg::SCR_SYNC_RUN);
        // Address and data are both held before a write executes.
        wr_go   = !wr_rsp_out.awready && !wr_rsp_out.wready && !wr_rsp_out.bvalid
                  && !(wr_sel == scr_pkg::SCR_REG_BOD && bod_run);
        wr_prot = write_protect_in && wr_sel != scr_pkg::SCR_REG_NONE
                  && wr_sel != scr_pkg::SCR_REG_FLAGS
                  && wr_sel != scr_pkg::SCR_REG_STATUS;
        rd_loop = (rd_sel == scr_pkg::SCR_REG_LOOP_VAL)
                  || (rd_sel == scr_pkg::SCR_REG_LOOP_MUL);
        rd_wait = (rd_sel == scr_pkg::SCR_REG_BOD && bod_run)
                  || (rd_loop && loop_st != scr_pkg::SCR_SYNC_DONE);
        rd_go   = !rd_rsp_out.arready && !rd_rsp_out.rvalid && !rd_wait;
    end

    // ****************************************************************
    // Read data mux
    // ****************************************************************
    always_comb begin
        rd_value = 32'h0000_0000;
        if (rd_sel == scr_pkg::SCR_REG_IEN_CLR || rd_sel == scr_pkg::SCR_REG_IEN_SET) begin
            rd_value = {20'h0_0000, ien};
        end else if (rd_sel == scr_pkg::SCR_REG_FLAGS) begin
            rd_value = {20'h0_0000, flags};
        end else if (rd_sel == scr_pkg::SCR_REG_STATUS) begin
            rd_value = {20'h0_0000, !bod_run, src_status_in};
        end else if (rd_sel == scr_pkg::SCR_REG_LOOP_VAL) begin
            rd_value = ctrl_out.loop_value;
        end else if (rd_sel == scr_pkg::SCR_REG_LOOP_MUL) begin
            rd_value = ctrl_out.loop_multiplier;
        end else if (rd_sel == scr_pkg::SCR_REG_BOD) begin
            rd_value = ctrl_out.brownout_control;
        end else if (rd_sel == scr_pkg::SCR_REG_REGULATOR) begin
            rd_value = {16'h0000, ctrl_out.regulator_control};
        end else if (rd_sel == scr_pkg::SCR_REG_VREF) begin
            rd_value = ctrl_out.reference_control;
        end
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_ien      = ien;
        next_bod_st   = bod_st;
        next_loop_st  = loop_st;
        next_bod_cnt  = bod_cnt;
        next_loop_cnt = loop_cnt;
        next_aw_addr  = aw_addr;
        next_ar_addr  = ar_addr;
        next_w_data   = w_data;
        next_w_strb   = w_strb;
        next_wr_rsp   = wr_rsp_out;
        next_rd_rsp   = rd_rsp_out;
        next_ctrl     = ctrl_out;
        bod_done      = 1'b0;
        flag_clr      = 12'h000;

        // Sync engines count down; the brown-out one returns to idle, the loop
        // one holds its fresh result until a read consumes it.
        case (bod_st)
            scr_pkg::SCR_SYNC_RUN: begin
                if (bod_cnt == 8'h00) begin
                    next_bod_st = scr_pkg::SCR_SYNC_IDLE;
                    bod_done    = 1'b1;
                end else begin
                    next_bod_cnt = bod_cnt - 8'h01;
                end
            end
            default: next_bod_st = scr_pkg::SCR_SYNC_IDLE;
        endcase
        case (loop_st)
            scr_pkg::SCR_SYNC_RUN: begin
                if (loop_cnt == 8'h00) begin
                    next_loop_st = scr_pkg::SCR_SYNC_DONE;
                end else begin
                    next_loop_cnt = loop_cnt - 8'h01;
                end
            end
            scr_pkg::SCR_SYNC_DONE: next_loop_st = scr_pkg::SCR_SYNC_DONE;
            default: next_loop_st = scr_pkg::SCR_SYNC_IDLE;
        endcase

        // Write channels.
        if (wr_req_in.awvalid && wr_rsp_out.awready) begin
            next_aw_addr        = wr_req_in.awaddr;
            next_wr_rsp.awready = 1'b0;
        end
        if (wr_req_in.wvalid && wr_rsp_out.wready) begin
            next_w_data        = wr_req_in.wdata;
            next_w_strb        = wr_req_in.wstrb;
            next_wr_rsp.wready = 1'b0;
        end
        if (wr_rsp_out.bvalid && wr_req_in.bready) begin
            next_wr_rsp.bvalid = 1'b0;
        end
        if (wr_go) begin
            next_wr_rsp.awready = 1'b1;
            next_wr_rsp.wready  = 1'b1;
            next_wr_rsp.bvalid  = 1'b1;
            next_wr_rsp.bresp   = `SCR_RESP_OKAY;
            if (wr_sel == scr_pkg::SCR_REG_NONE) begin
                next_wr_rsp.bresp = `SCR_RESP_DECERR;
            end else if (wr_prot) begin
                next_wr_rsp.bresp = `SCR_RESP_SLVERR;
            end else if (wr_sel == scr_pkg::SCR_REG_IEN_CLR) begin
                next_ien = ien & ~bmask[11:0];
            end else if (wr_sel == scr_pkg::SCR_REG_IEN_SET) begin
                next_ien = ien | bmask[11:0];
            end else if (wr_sel == scr_pkg::SCR_REG_FLAG_CLR) begin
                flag_clr = bmask[11:0];
            end else if (wr_sel == scr_pkg::SCR_REG_LOOP_VAL) begin
                next_ctrl.loop_value = scr_merge(ctrl_out.loop_value, w_data,
                                                 scr_lanes(w_strb));
            end else if (wr_sel == scr_pkg::SCR_REG_LOOP_MUL) begin
                next_ctrl.loop_multiplier = scr_merge(ctrl_out.loop_multiplier, w_data,
                                                      scr_lanes(w_strb));
            end else if (wr_sel == scr_pkg::SCR_REG_LOOP_SYNC) begin
                if (bmask[`SCR_READ_REQ_BIT] && loop_st != scr_pkg::SCR_SYNC_RUN) begin
                    next_loop_st  = scr_pkg::SCR_SYNC_RUN;
                    next_loop_cnt = SYNC_LOAD;
                end
            end else if (wr_sel == scr_pkg::SCR_REG_BOD) begin
                next_ctrl.brownout_control = scr_merge(ctrl_out.brownout_control, w_data,
                                                       scr_lanes(w_strb));
                next_bod_st  = scr_pkg::SCR_SYNC_RUN;
                next_bod_cnt = SYNC_LOAD;
            end else if (wr_sel == scr_pkg::SCR_REG_REGULATOR) begin
                next_ctrl.regulator_control = 16'(scr_merge(
                    {16'h0000, ctrl_out.regulator_control}, w_data,
                    scr_lanes(w_strb) & `SCR_REGULATOR_MASK));
            end else if (wr_sel == scr_pkg::SCR_REG_VREF) begin
                next_ctrl.reference_control = scr_merge(ctrl_out.reference_control, w_data,
                                                        scr_lanes(w_strb));
            end
        end

        // Read channels.
        if (rd_req_in.arvalid && rd_rsp_out.arready) begin
            next_ar_addr        = rd_req_in.araddr;
            next_rd_rsp.arready = 1'b0;
        end
        if (rd_rsp_out.rvalid && rd_req_in.rready) begin
            next_rd_rsp.rvalid = 1'b0;
        end
        // A loop read with no fresh sync starts one itself and holds the bus.
        if (!rd_rsp_out.arready && !rd_rsp_out.rvalid && rd_loop
            && loop_st == scr_pkg::SCR_SYNC_IDLE) begin
            next_loop_st  = scr_pkg::SCR_SYNC_RUN;
            next_loop_cnt = SYNC_LOAD;
        end
        if (rd_go) begin
            next_rd_rsp.arready = 1'b1;
            next_rd_rsp.rvalid  = 1'b1;
            next_rd_rsp.rdata   = rd_value;
            next_rd_rsp.rresp   = (rd_sel == scr_pkg::SCR_REG_NONE) ?
                                  `SCR_RESP_DECERR : `SCR_RESP_OKAY;
            if (rd_loop) begin
                next_loop_st = scr_pkg::SCR_SYNC_IDLE;
            end
        end

        // A new event wins over a clear in the same cycle.
        next_flags = (flags & ~flag_clr) | {bod_done, src_event_in};
        next_irq   = |(next_flags & next_ien);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ien        <= `SCR_IEN_RESET;
            flags      <= 12'h000;
            bod_st     <= scr_pkg::SCR_SYNC_IDLE;
            loop_st    <= scr_pkg::SCR_SYNC_IDLE;
            bod_cnt    <= 8'h00;
            loop_cnt   <= 8'h00;
            aw_addr    <= 8'h00;
            ar_addr    <= 8'h00;
            w_data     <= 32'h0000_0000;
            w_strb     <= 4'h0;
            wr_rsp_out <= '{awready: 1'b1, wready: 1'b1, bresp: `SCR_RESP_OKAY,
                            bvalid: 1'b0};
            rd_rsp_out <= '{arready: 1'b1, rdata: 32'h0000_0000,
                            rresp: `SCR_RESP_OKAY, rvalid: 1'b0};
            ctrl_out   <= '{`SCR_CTRL_RESET, `SCR_CTRL_RESET, `SCR_CTRL_RESET,
                            16'h0000, `SCR_CTRL_RESET};
            irq_out    <= 1'b0;
        end else begin
            ien        <= next_ien;
            flags      <= next_flags;
            bod_st     <= next_bod_st;
            loop_st    <= next_loop_st;
            bod_cnt    <= next_bod_cnt;
            loop_cnt   <= next_loop_cnt;
            aw_addr    <= next_aw_addr;
            ar_addr    <= next_ar_addr;
            w_data     <= next_w_data;
            w_strb     <= next_w_strb;
            wr_rsp_out <= next_wr_rsp;
            rd_rsp_out <= next_rd_rsp;
            ctrl_out   <= next_ctrl;
            irq_out    <= next_irq;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    lane_whole_a: assert property (
        wr_go && !wr_prot && wr_sel == scr_pkg::SCR_REG_VREF && w_strb == 4'hF
        |=> ctrl_out.reference_control == $past(w_data))
        else $error("full word write not stored");

    lane_byte_a: assert property (
        wr_go && !wr_prot && wr_sel == scr_pkg::SCR_REG_VREF && w_strb == 4'h1
        |=> ctrl_out.reference_control[31:8] == $past(ctrl_out.reference_control[31:8])
            && ctrl_out.reference_control[7:0] == $past(w_data[7:0]))
        else $error("byte write touched other lanes");

    bod_stall_a: assert property (
        !rd_rsp_out.arready && rd_sel == scr_pkg::SCR_REG_BOD && bod_run
        |=> !rd_rsp_out.rvalid)
        else $error("brown-out read answered during sync");

    protect_block_a: assert property (
        wr_go && wr_prot
        |=> ien == $past(ien) && wr_rsp_out.bresp == `SCR_RESP_SLVERR
            && ctrl_out == $past(ctrl_out))
        else $error("protected write took effect");

    clear_keep_a: assert property (
        wr_go && !wr_prot && wr_sel == scr_pkg::SCR_REG_IEN_CLR
        |=> (ien & ~$past(bmask[11:0])) == ($past(ien) & ~$past(bmask[11:0])))
        else $error("zero bit changed an enable");

    clear_one_a: assert property (
        wr_go && !wr_prot && wr_sel == scr_pkg::SCR_REG_IEN_CLR
        |=> (ien & $past(bmask[11:0])) == 12'h000)
        else $error("one bit did not clear an enable");

    irq_level_a: assert property (
        ##1 irq_out == |(flags & ien))
        else $error("interrupt does not follow enabled flags");

    sync_flag_a: assert property (
        bod_run && bod_cnt == 8'h00 |=> flags[`SCR_SYNC_RDY_BIT]
            && irq_out == |(flags & ien))
        else $error("sync ready flag not raised at bit 11");

    bod_ready_a: assert property (
        wr_go && !wr_prot && wr_sel == scr_pkg::SCR_REG_BOD
        |=> bod_run ##[1:300] !bod_run)
        else $error("brown-out sync ready not cleared then restored");

    loop_stall_a: assert property (
        !rd_rsp_out.arready && !rd_rsp_out.rvalid && rd_loop
        && loop_st == scr_pkg::SCR_SYNC_IDLE
        |=> loop_st == scr_pkg::SCR_SYNC_RUN && !rd_rsp_out.rvalid
            ##[1:300] rd_rsp_out.rvalid)
        else $error("loop read did not sync and stall");

    reset_zero_a: assert property (
        $past(sys_rst_in) |-> ien == 12'h000 && flags == 12'h000 && !irq_out)
        else $error("enables not zero after reset");

endmodule : scr_top

`default_nettype wire

// *** verilog/scr_regs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the
//          system controller register front end.
// Assumes: Byte addresses on an 8-bit AXI4-Lite address, one word per register.
// Notes:   Definitions only; included by the package users.
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SCR_OFF_IEN_CLR   8'h00
`define SCR_OFF_IEN_SET   8'h04
`define SCR_OFF_FLAGS     8'h08
`define SCR_OFF_STATUS    8'h0C
`define SCR_OFF_LOOP_VAL  8'h28
`define SCR_OFF_LOOP_MUL  8'h2C
`define SCR_OFF_LOOP_SYNC 8'h30
`define SCR_OFF_BOD       8'h34
`define SCR_OFF_REGULATOR 8'h3C
`define SCR_OFF_VREF      8'h40
`define SCR_OFF_FLAG_CLR  8'h48

// ****************************************************************
// Fields, reset values, answers and timing
// ****************************************************************
`define SCR_SYNC_RDY_BIT  11
`define SCR_READ_REQ_BIT  0
`define SCR_IEN_RESET     12'h000
`define SCR_CTRL_RESET    32'h0000_0000
`define SCR_REGULATOR_MASK 32'h0000_FFFF
`define SCR_RESP_OKAY     2'h0
`define SCR_RESP_SLVERR   2'h2
`define SCR_RESP_DECERR   2'h3
`define SCR_SYNC_CYCLES   4

`endif

// *** verilog/scr_pkg.sv ***
// Purpose: Types shared by the system controller register front end.
// Assumes: AXI4-Lite with 8-bit addresses and 32-bit data.
// Notes:   Constants live in scr_regs.svh.
`default_nettype none

package scr_pkg;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
    } scr_wr_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
    } scr_wr_rsp_t;

    typedef struct packed {
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } scr_rd_req_t;

    typedef struct packed {
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } scr_rd_rsp_t;

    typedef struct packed {
        logic [31:0] loop_value;
        logic [31:0] loop_multiplier;
        logic [31:0] brownout_control;
        logic [15:0] regulator_control;
        logic [31:0] reference_control;
    } scr_ctrl_t;

    typedef enum logic [3:0] {
        SCR_REG_NONE      = 4'b0000,
        SCR_REG_IEN_CLR   = 4'b0001,
        SCR_REG_IEN_SET   = 4'b0010,
        SCR_REG_FLAGS     = 4'b0011,
        SCR_REG_STATUS    = 4'b0100,
        SCR_REG_FLAG_CLR  = 4'b0101,
        SCR_REG_LOOP_VAL  = 4'b0110,
        SCR_REG_LOOP_MUL  = 4'b0111,
        SCR_REG_LOOP_SYNC = 4'b1000,
        SCR_REG_BOD       = 4'b1001,
        SCR_REG_REGULATOR = 4'b1010,
        SCR_REG_VREF      = 4'b1011
    } scr_reg_t;

    typedef enum logic [1:0] {
        SCR_SYNC_IDLE = 2'b00,
        SCR_SYNC_RUN  = 2'b01,
        SCR_SYNC_DONE = 2'b10
    } scr_sync_t;

endpackage : scr_pkg

`default_nettype wire

// *** dv/scr_host_model.sv ***
// Purpose: Bus master model standing in for the processor core.
// Assumes: AXI4-Lite, one write and one read at most under way.
// Notes:   Waits without limit; the bench watchdog ends a hang.
`timescale 1ns/1ns
`default_nettype none
module scr_host_model (
    // Clock.
    input  wire logic                 clk_in,
    // Register bus.
    output var  scr_pkg::scr_wr_req_t wr_req_out,
    input  wire scr_pkg::scr_wr_rsp_t wr_rsp_in,
    output var  scr_pkg::scr_rd_req_t rd_req_out,
    input  wire scr_pkg::scr_rd_rsp_t rd_rsp_in
);
    initial begin
        wr_req_out = '0;
        rd_req_out = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge clk_in);
        wr_req_out <= '{a, 1'b1, d, s, 1'b1, 1'b1};
        do begin
            @(posedge clk_in);
            if (wr_rsp_in.awready) wr_req_out.awvalid <= 1'b0;
            if (wr_rsp_in.wready) wr_req_out.wvalid <= 1'b0;
        end while (!wr_rsp_in.bvalid);
        r = wr_rsp_in.bresp;
        wr_req_out.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_in);
        rd_req_out <= '{a, 1'b1, 1'b1};
        do begin
            @(posedge clk_in);
            if (rd_rsp_in.arready) rd_req_out.arvalid <= 1'b0;
        end while (!rd_rsp_in.rvalid);
        d = rd_rsp_in.rdata;
        r = rd_rsp_in.rresp;
        rd_req_out.rready <= 1'b0;
    endtask : rd
endmodule : scr_host_model
`default_nettype wire

// *** dv/tb_sysctrl_irq_enable_regs.sv ***
// Purpose: Self-checking bench of the register front end.
// Assumes: SYNC_CYCLES of 8 keeps the brown-out sync visible to a poll.
// Notes:   Scenarios run in order; enable values carry over.
`timescale 1ns/1ns
`default_nettype none
module tb_sysctrl_irq_enable_regs;
    logic                 sys_clk_in = 1'b0;
    logic                 sys_rst_in = 1'b1;
    logic [10:0]          src_event_in = 11'h000;
    logic                 write_protect_in = 1'b0;
    logic                 irq_out;
    scr_pkg::scr_wr_req_t wq;
    scr_pkg::scr_wr_rsp_t ws;
    scr_pkg::scr_rd_req_t rq;
    scr_pkg::scr_rd_rsp_t rs;
    scr_pkg::scr_ctrl_t   ctrl;
    int                   failures = 0;
    int                   cmp_count = 0;
    logic [31:0]          d;
    logic [1:0]           r;
    always #50 sys_clk_in = ~sys_clk_in;
    scr_top #(.SYNC_CYCLES(8)) scr_top_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .wr_req_in(wq), .wr_rsp_out(ws), .rd_req_in(rq), .rd_rsp_out(rs),
        .src_event_in(src_event_in), .src_status_in(11'h000),
        .write_protect_in(write_protect_in), .ctrl_out(ctrl), .irq_out(irq_out));
    scr_host_model scr_host_model_inst (.clk_in(sys_clk_in), .wr_req_out(wq),
        .wr_rsp_in(ws), .rd_req_out(rq), .rd_rsp_in(rs));
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        scr_host_model_inst.wr(a, v, s, r);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        scr_host_model_inst.rd(a, d, r);
    endtask : rd
    task automatic irq_is(input logic e);
        repeat (2) @(posedge sys_clk_in);
        chk("irq", {31'b0, irq_out}, {31'b0, e});
    endtask : irq_is
    task automatic t_enables;
        rd(8'h00);
        chk("enables reset", d, 32'h0000_0000);
        wr(8'h04, 32'hFFFF_FFFF, 4'hF);
        rd(8'h00);
        chk("all enables", d, 32'h0000_0FFF);
        wr(8'h00, 32'hFFFF_08FF, 4'b0010);
        rd(8'h00);
        chk("byte clear", d, 32'h0000_07FF);
        wr(8'h00, 32'hFFFF_0003, 4'b0011);
        rd(8'h00);
        chk("half clear", d, 32'h0000_07FC);
    endtask : t_enables
    task automatic t_irq;
        @(posedge sys_clk_in);
        src_event_in <= 11'h008;
        @(posedge sys_clk_in);
        src_event_in <= 11'h000;
        irq_is(1'b1);
        wr(8'h00, 32'h0000_0008, 4'hF);
        irq_is(1'b0);
    endtask : t_irq
    task automatic t_sync;
        wr(8'h34, 32'h0012_0102, 4'hF);
        rd(8'h0C);
        chk("sync busy", {31'b0, d[11]}, 32'h0);
        rd(8'h34);
        chk("bod readback", d, 32'h0012_0102);
        chk("bod value", ctrl.brownout_control, 32'h0012_0102);
        rd(8'h0C);
        chk("sync ready", {31'b0, d[11]}, 32'h1);
        irq_is(1'b0);
        wr(8'h04, 32'h0000_0800, 4'hF);
        irq_is(1'b1);
    endtask : t_sync
    task automatic t_protect;
        @(posedge sys_clk_in);
        write_protect_in <= 1'b1;
        wr(8'h00, 32'h0000_0FFF, 4'hF);
        chk("protect resp", {30'b0, r}, 32'h2);
        rd(8'h00);
        chk("protect kept", d, 32'h0000_0FF4);
        write_protect_in <= 1'b0;
    endtask : t_protect
    task automatic t_loop;
        wr(8'h28, 32'hABCD_1234, 4'hF);
        rd(8'h28);
        chk("loop stall read", d, 32'hABCD_1234);
        wr(8'h2C, 32'h0000_5A5A, 4'hF);
        wr(8'h30, 32'h0000_0001, 4'hF);
        rd(8'h2C);
        chk("loop req read", d, 32'h0000_5A5A);
        rd(8'h50);
        chk("unmapped", {30'b0, r}, 32'h3);
    endtask : t_loop
    task automatic t_lanes;
        wr(8'h40, 32'h1234_5678, 4'hF);
        wr(8'h40, 32'hFFFF_FFAB, 4'h1);
        wr(8'h42, 32'hBEEF_0000, 4'hC);
        rd(8'h40);
        chk("lane merge", d, 32'hBEEF_56AB);
        chk("reference value", ctrl.reference_control, 32'hBEEF_56AB);
        wr(8'h3C, 32'hFFFF_C3A5, 4'hF);
        chk("regulator value", {16'h0000, ctrl.regulator_control}, 32'h0000_C3A5);
        rd(8'h08);
        chk("flags", d, 32'h0000_0808);
        wr(8'h48, 32'h0000_0808, 4'hF);
        irq_is(1'b0);
        rd(8'h08);
        chk("flags cleared", d, 32'h0000_0000);
        @(posedge sys_clk_in);
        sys_rst_in <= 1'b1;
        @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        rd(8'h00);
        chk("enables after reset", d, 32'h0000_0000);
        chk("irq after reset", {31'b0, irq_out}, 32'h0);
    endtask : t_lanes
    task automatic print_verdict;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        t_enables();
        t_irq();
        t_sync();
        t_protect();
        t_loop();
        t_lanes();
        print_verdict();
    end
    // The whole run needs well under 400 cycles, so this only trips on a hang.
    initial begin
        repeat (4000) @(posedge sys_clk_in);
        failures++;
        print_verdict();
    end
endmodule : tb_sysctrl_irq_enable_regs
`default_nettype wire
